// *** verilog/vts_defs.svh ***
/*
 Constants for the velocity threshold mode select block:
 interval width, saturation value, hysteresis shifts, register offsets.
 Assumes inclusion by bare name from the package and the design file.
*/
`ifndef VTS_DEFS_SVH
`define VTS_DEFS_SVH

`define VTS_IW 20
`define VTS_IV_MAX 20'hFFFFF
`define VTS_HYST_BIG_SH 4
`define VTS_HYST_SMALL_SH 5
`define VTS_MS_W 10
`define VTS_MS_45 10'h080
`define VTS_TOFF_W 4

`define VTS_A_QUIET 4'h0
`define VTS_A_LOAD 4'h1
`define VTS_A_HIGH 4'h2
`define VTS_A_CFG 4'h3
`define VTS_A_INTERVAL 4'h4
`define VTS_A_MODE 4'h5
`define VTS_A_STAT 4'h6
`define VTS_A_MASK 4'h7

`define VTS_CFG_PWM 0
`define VTS_CFG_LOAD 1
`define VTS_CFG_STALL 2
`define VTS_CFG_VHCHM 3
`define VTS_CFG_VHFS 4
`define VTS_CFG_SMALLH 5
`define VTS_CFG_W 6

`define VTS_EV_W 3
`define VTS_EV_HIGH 0
`define VTS_EV_FS 1
`define VTS_EV_QUIET 2

`endif

// *** verilog/vts_pkg.sv ***
/*
 Types for the velocity threshold mode select block.
 Assumes vts_defs.svh is on the include path.
*/
`include "vts_defs.svh"

package vts_pkg;
    typedef enum logic [1:0] {
        VTS_FS_OFF = 2'b01,
        VTS_FS_ON = 2'b10
    } vts_fs_state_t;
endpackage

// *** verilog/vts_mode_select.sv ***
/*
 Velocity threshold mode select: compares the microstep interval against
 three thresholds and derives the feature enables for a stepper driver.
 Assumes synchronous inputs on clk and a simple strobed register port.
*/
`include "vts_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module vts_mode_select
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic step_pulse,
    input wire logic [`VTS_MS_W-1:0] ms_position,
    input wire logic [7:0] table_current,
    input wire logic [`VTS_TOFF_W-1:0] toff_setting,
    input wire logic stall_detect_load,
    input wire logic stall_detect_speed,
    output logic quiet_pwm_en,
    output logic load_speed_en,
    output logic load_adapt_en,
    output logic stop_on_stall_en,
    output logic stall_out,
    output logic const_toff_chopper,
    output logic fast_decay_time,
    output logic chopper_sync_en,
    output logic fullstep_mode,
    output logic [7:0] fullstep_current,
    output logic [`VTS_TOFF_W:0] toff_effective,
    output logic irq
);
    logic [`VTS_IW-1:0] quiet_reg;
    logic [`VTS_IW-1:0] load_reg;
    logic [`VTS_IW-1:0] high_reg;
    logic [`VTS_CFG_W-1:0] cfg_reg;
    logic [`VTS_IW-1:0] count_reg;
    logic [`VTS_IW-1:0] interval_reg;
    logic sample_reg;
    logic [`VTS_EV_W-1:0] stat_reg;
    logic [`VTS_EV_W-1:0] mask_reg;
    logic [`VTS_EV_W-1:0] event_vec;
    logic in_quiet_reg;
    logic in_load_reg;
    logic in_high_reg;
    logic high_prev_reg;
    logic quiet_prev_reg;
    logic [7:0] fs_current_reg;
    vts_pkg::vts_fs_state_t fs_reg;
    logic [`VTS_IW-1:0] upper_cmp;
    logic [`VTS_IW-1:0] hyst_term;
    logic at_45;

    // Interval counter saturates so standstill reads all ones
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            count_reg <= '0;
            interval_reg <= `VTS_IV_MAX;
            sample_reg <= 1'b0;
        end
        else
        begin
            sample_reg <= step_pulse;
            if (step_pulse)
            begin
                // Count the step edge itself so the interval equals the period
                if (count_reg == `VTS_IV_MAX)
                    interval_reg <= `VTS_IV_MAX;
                else
                    interval_reg <= count_reg + 20'h00001;
                count_reg <= '0;
            end
            else if (count_reg != `VTS_IV_MAX)
                count_reg <= count_reg + 20'h00001;
            else
                interval_reg <= `VTS_IV_MAX;
        end
    end

    // Upper comparisons use a shrunk interval to give hysteresis
    always_comb
    begin
        if (cfg_reg[`VTS_CFG_SMALLH])
            hyst_term = interval_reg >> `VTS_HYST_SMALL_SH;
        else
            hyst_term = interval_reg >> `VTS_HYST_BIG_SH;
        if (interval_reg > hyst_term)
            upper_cmp = interval_reg - hyst_term - 20'h00001;
        else
            upper_cmp = '0;
    end

    // Comparisons are held between samples, except while the interval is saturated, so modes do not flicker
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            in_quiet_reg <= 1'b1;
            in_load_reg <= 1'b0;
            in_high_reg <= 1'b0;
        end
        else if (sample_reg || interval_reg == `VTS_IV_MAX)
        begin
            in_quiet_reg <= interval_reg >= quiet_reg;
            in_load_reg <= load_reg >= upper_cmp;
            in_high_reg <= upper_cmp <= high_reg;
        end
    end

    always_comb
    begin
        quiet_pwm_en = cfg_reg[`VTS_CFG_PWM] && in_quiet_reg
            && !in_load_reg && !in_high_reg;
        load_speed_en = !in_quiet_reg;
        load_adapt_en = cfg_reg[`VTS_CFG_LOAD] && in_load_reg
            && !in_high_reg;
        stop_on_stall_en = cfg_reg[`VTS_CFG_STALL] && in_load_reg;
        const_toff_chopper = in_high_reg && cfg_reg[`VTS_CFG_VHCHM];
        fast_decay_time = !const_toff_chopper;
        chopper_sync_en = !const_toff_chopper;
        fullstep_mode = fs_reg == vts_pkg::VTS_FS_ON;
        stall_out = stop_on_stall_en && (fullstep_mode ? stall_detect_speed
            : stall_detect_load);
        fullstep_current = fs_current_reg;
        if (const_toff_chopper)
            toff_effective = {toff_setting, 1'b0};
        else
            toff_effective = {1'b0, toff_setting};
        irq = |(stat_reg & mask_reg);
    end

    assign at_45 = ms_position == `VTS_MS_45;

    // Fullstep entry waits for the 45 degree point to avoid a current jump
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            fs_reg <= vts_pkg::VTS_FS_OFF;
            fs_current_reg <= 8'h00;
        end
        else
        begin
            unique case (fs_reg)
                vts_pkg::VTS_FS_OFF:
                    if (in_high_reg && cfg_reg[`VTS_CFG_VHFS] && at_45)
                    begin
                        fs_reg <= vts_pkg::VTS_FS_ON;
                        fs_current_reg <= table_current;
                    end
                vts_pkg::VTS_FS_ON:
                    if (!in_high_reg || !cfg_reg[`VTS_CFG_VHFS])
                        fs_reg <= vts_pkg::VTS_FS_OFF;
            endcase
        end
    end

    assign event_vec = {(in_quiet_reg && !quiet_prev_reg),
        (fs_reg == vts_pkg::VTS_FS_OFF && in_high_reg
            && cfg_reg[`VTS_CFG_VHFS] && at_45),
        (in_high_reg && !high_prev_reg)};

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            stat_reg <= '0;
            high_prev_reg <= 1'b0;
            quiet_prev_reg <= 1'b1;
        end
        else
        begin
            high_prev_reg <= in_high_reg;
            quiet_prev_reg <= in_quiet_reg;
            // Set wins over a write-one clear in the same cycle
            if (reg_wr && reg_addr == `VTS_A_STAT)
                stat_reg <= (stat_reg & ~reg_wdata[`VTS_EV_W-1:0]) | event_vec;
            else
                stat_reg <= stat_reg | event_vec;
        end
    end

    // Thresholds are 20 bits wide so any value 0..1048575 is accepted
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            quiet_reg <= '0;
            load_reg <= '0;
            high_reg <= '0;
            cfg_reg <= '0;
            mask_reg <= '0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `VTS_A_QUIET: quiet_reg <= reg_wdata[`VTS_IW-1:0];
                `VTS_A_LOAD: load_reg <= reg_wdata[`VTS_IW-1:0];
                `VTS_A_HIGH: high_reg <= reg_wdata[`VTS_IW-1:0];
                `VTS_A_CFG: cfg_reg <= reg_wdata[`VTS_CFG_W-1:0];
                `VTS_A_MASK: mask_reg <= reg_wdata[`VTS_EV_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `VTS_A_QUIET: reg_rdata <= {12'h000, quiet_reg};
                `VTS_A_LOAD: reg_rdata <= {12'h000, load_reg};
                `VTS_A_HIGH: reg_rdata <= {12'h000, high_reg};
                `VTS_A_CFG: reg_rdata <= {26'h0000000, cfg_reg};
                `VTS_A_INTERVAL: reg_rdata <= {12'h000, interval_reg};
                `VTS_A_MODE: reg_rdata <= {26'h0000000, fullstep_mode,
                    const_toff_chopper, stop_on_stall_en, load_adapt_en,
                    load_speed_en, quiet_pwm_en};
                `VTS_A_STAT: reg_rdata <= {29'h00000000, stat_reg};
                `VTS_A_MASK: reg_rdata <= {29'h00000000, mask_reg};
                default: reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end

    property p_quiet_off_high;
        @(posedge clk) disable iff (!rst_b)
        in_high_reg |-> !quiet_pwm_en && !load_adapt_en;
    endproperty
    a_quiet_off_high: assert property (p_quiet_off_high)
        else $error("quiet or load-adapt active at high speed");

    property p_fs_at_45;
        @(posedge clk) disable iff (!rst_b)
        $rose(fullstep_mode) |-> $past(at_45);
    endproperty
    a_fs_at_45: assert property (p_fs_at_45)
        else $error("fullstep entered away from 45 degrees");

    property p_toff_double;
        @(posedge clk) disable iff (!rst_b)
        const_toff_chopper |-> toff_effective == {toff_setting, 1'b0};
    endproperty
    a_toff_double: assert property (p_toff_double)
        else $error("off time not doubled");

    property p_sat;
        @(posedge clk) disable iff (!rst_b)
        (count_reg == `VTS_IV_MAX && !step_pulse) |=>
            interval_reg == `VTS_IV_MAX;
    endproperty
    a_sat: assert property (p_sat)
        else $error("interval did not saturate");

    property p_chop;
        @(posedge clk) disable iff (!rst_b)
        const_toff_chopper |-> !fast_decay_time && !chopper_sync_en
            && in_high_reg;
    endproperty
    a_chop: assert property (p_chop)
        else $error("chopper switch wrong");

    property p_quiet_global;
        @(posedge clk) disable iff (!rst_b)
        quiet_pwm_en |-> cfg_reg[`VTS_CFG_PWM] && in_quiet_reg;
    endproperty
    a_quiet_global: assert property (p_quiet_global)
        else $error("quiet mode outside enable");

    property p_stall;
        @(posedge clk) disable iff (!rst_b)
        stall_out |-> stop_on_stall_en && in_load_reg;
    endproperty
    a_stall: assert property (p_stall)
        else $error("stall output outside range");

    property p_eval;
        @(posedge clk) disable iff (!rst_b)
        sample_reg |=> in_quiet_reg == ($past(interval_reg)
            >= $past(quiet_reg));
    endproperty
    a_eval: assert property (p_eval)
        else $error("comparison not refreshed");

    sequence s_fs_entry;
        fs_reg == vts_pkg::VTS_FS_OFF && in_high_reg
            && cfg_reg[`VTS_CFG_VHFS] && at_45;
    endsequence

    property p_fs_current;
        @(posedge clk) disable iff (!rst_b)
        s_fs_entry |=> fullstep_mode
            && fullstep_current == $past(table_current);
    endproperty
    a_fs_current: assert property (p_fs_current)
        else $error("fullstep current not taken at entry");

    property p_fs_exit;
        @(posedge clk) disable iff (!rst_b)
        fullstep_mode && !in_high_reg |=> !fullstep_mode;
    endproperty
    a_fs_exit: assert property (p_fs_exit)
        else $error("fullstep kept outside high range");

    property p_load_quiet;
        @(posedge clk) disable iff (!rst_b)
        in_load_reg && !in_high_reg |-> !quiet_pwm_en;
    endproperty
    a_load_quiet: assert property (p_load_quiet)
        else $error("quiet mode active in load-adapt range");

    property p_stall_route;
        @(posedge clk) disable iff (!rst_b)
        fullstep_mode && stop_on_stall_en |-> stall_out == stall_detect_speed;
    endproperty
    a_stall_route: assert property (p_stall_route)
        else $error("stall output not from speed detector");

    property p_speed_off;
        @(posedge clk) disable iff (!rst_b)
        in_quiet_reg |-> !load_speed_en;
    endproperty
    a_speed_off: assert property (p_speed_off)
        else $error("load speed mode on in quiet range");
endmodule

`default_nettype wire

// *** dv/test_velocity_threshold_mode_select.sv ***
/*
 Self-checking bench for the velocity threshold mode select block.
 Assumes vts_defs.svh on the include path and the design compiled first.
*/
`include "vts_defs.svh"
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
$display("ERROR t=%0t got %0h exp %0h", $time, g, e); end end

module test_velocity_threshold_mode_select;
    logic clk, rst_b, reg_wr, reg_rd, step_pulse;
    logic stall_detect_load, stall_detect_speed;
    logic [3:0] reg_addr, toff_setting;
    logic [31:0] reg_wdata, reg_rdata, rd;
    logic [9:0] ms_position;
    logic [7:0] table_current, fullstep_current, cur;
    logic [4:0] toff_effective;
    logic quiet_pwm_en, load_speed_en, load_adapt_en, stop_on_stall_en;
    logic stall_out, const_toff_chopper, fast_decay_time, chopper_sync_en;
    logic fullstep_mode, irq;
    logic [5:0] c, em;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int per = 0;
    int cnt = 0;
    int q, l, h;

    vts_mode_select u_dut
    (
        .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .step_pulse, .ms_position, .table_current, .toff_setting,
        .stall_detect_load, .stall_detect_speed, .quiet_pwm_en,
        .load_speed_en, .load_adapt_en, .stop_on_stall_en, .stall_out,
        .const_toff_chopper, .fast_decay_time, .chopper_sync_en,
        .fullstep_mode, .fullstep_current, .toff_effective, .irq
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Steady step train; per of zero leaves the motor at standstill
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            num_errors++;
            summarize();
        end
        if (per != 0 && cnt >= per - 1)
        begin
            cnt <= 0;
            step_pulse <= 1'b1;
        end
        else
        begin
            cnt <= cnt + 1;
            step_pulse <= 1'b0;
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Comparisons move only after a step or while the interval is saturated, so wait two full steps
    task automatic settle();
        tick(2 * per + 6);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Thresholds within 3 of the raw or scaled interval are off by one risks
    function automatic bit near(int t, int p);
        int d[3];
        d = '{p, p - (p >> `VTS_HYST_BIG_SH) - 1,
              p - (p >> `VTS_HYST_SMALL_SH) - 1};
        foreach (d[k])
            if (t - d[k] <= 3 && d[k] - t <= 3)
                return 1'b1;
        return 1'b0;
    endfunction

    function automatic logic [5:0] expect_mode(int p, int q, int l, int h,
        logic [5:0] c);
        int hv;
        logic qk, lk, hk;
        hv = p - (p >> (c[`VTS_CFG_SMALLH] ? `VTS_HYST_SMALL_SH
            : `VTS_HYST_BIG_SH)) - 1;
        qk = p >= q;
        lk = l >= hv;
        hk = hv <= h;
        expect_mode[0] = c[`VTS_CFG_PWM] & qk & !lk & !hk;
        expect_mode[1] = !qk;
        expect_mode[2] = c[`VTS_CFG_LOAD] & lk & !hk;
        expect_mode[3] = c[`VTS_CFG_STALL] & lk;
        expect_mode[4] = c[`VTS_CFG_VHCHM] & hk;
        expect_mode[5] = 1'b0;
    endfunction

    initial
    begin
        {rst_b, reg_wr, reg_rd, step_pulse, reg_addr, reg_wdata} = '0;
        {stall_detect_load, stall_detect_speed, toff_setting} = '0;
        {ms_position, table_current} = '0;
        void'($urandom(32'h2233D157));
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        `CHK({quiet_pwm_en, load_speed_en, load_adapt_en, irq}, 4'h0)
        `CHK({fast_decay_time, chopper_sync_en}, 2'b11)
        wr(4'h9, 32'h5);
        wr(`VTS_A_INTERVAL, 32'h0);
        for (int a = 0; a < 16; a++)
        begin
            if (a != `VTS_A_STAT)
            begin
                rdr(4'(a), rd);
                `CHK(rd, a == 4 ? {12'h0, `VTS_IV_MAX} : 32'h0)
            end
        end
        $display("reset test done");
        for (int i = 0; i < 20; i++)
        begin
            per = i < 2 ? 320 : 40 + $urandom_range(360);
            c = i < 2 ? {i[0], 5'h08} : 6'($urandom_range(63));
            {q, l, h} = {32'd0, 32'd1000, 32'd304};
            if (i >= 2)
            begin
                do q = $urandom_range(500); while (near(q, per));
                do l = $urandom_range(500); while (near(l, per));
                do h = $urandom_range(500); while (near(h, per));
            end
            toff_setting <= 4'($urandom);
            stall_detect_load <= 1'($urandom);
            stall_detect_speed <= 1'($urandom);
            wr(`VTS_A_QUIET, 32'(q));
            wr(`VTS_A_LOAD, 32'(l));
            wr(`VTS_A_HIGH, 32'(h));
            wr(`VTS_A_CFG, {26'h0, c});
            settle();
            em = expect_mode(per, q, l, h, c);
            `CHK(quiet_pwm_en, em[0])
            `CHK(load_speed_en, em[1])
            `CHK(load_adapt_en, em[2])
            `CHK(stop_on_stall_en, em[3])
            `CHK(stall_out, em[3] & stall_detect_load)
            `CHK(const_toff_chopper, em[4])
            `CHK({fast_decay_time, chopper_sync_en}, {2{!em[4]}})
            `CHK(toff_effective, em[4] ? {toff_setting, 1'b0} : {1'b0, toff_setting})
            rdr(`VTS_A_MODE, rd);
            `CHK(rd[5:0], em)
            $display("random case %0d done", i);
        end
        per = 40;
        toff_setting <= 4'h5;
        ms_position <= 10'h07F;
        wr(`VTS_A_MASK, 32'h3);
        wr(`VTS_A_HIGH, 32'h0);
        wr(`VTS_A_LOAD, 32'd1000);
        wr(`VTS_A_CFG, 32'h0);
        settle();
        wr(`VTS_A_STAT, 32'h7);
        tick(2);
        `CHK(irq, 1'b0)
        wr(`VTS_A_CFG, 32'h1C);
        wr(`VTS_A_HIGH, 32'd1000);
        settle();
        `CHK(fullstep_mode, 1'b0)
        `CHK(irq, 1'b1)
        `CHK(toff_effective, 5'h0A)
        cur = 8'($urandom);
        stall_detect_load <= 1'b0;
        stall_detect_speed <= 1'b1;
        ms_position <= `VTS_MS_45;
        table_current <= cur;
        @(posedge clk);
        ms_position <= 10'h081;
        table_current <= ~cur;
        tick(3);
        `CHK(fullstep_mode, 1'b1)
        `CHK(fullstep_current, cur)
        `CHK(stall_out, 1'b1)
        rdr(`VTS_A_STAT, rd);
        `CHK(rd[1:0], 2'b11)
        wr(`VTS_A_MASK, 32'h0);
        tick(2);
        `CHK(irq, 1'b0)
        wr(`VTS_A_CFG, 32'h0C);
        tick(3);
        `CHK(fullstep_mode, 1'b0)
        `CHK(stall_out, 1'b0)
        $display("fullstep test done");
        summarize();
    end
endmodule

`default_nettype wire
